// *** hdl/boundary_scan_regs.vh ***
`ifndef BOUNDARY_SCAN_REGS_VH
`define BOUNDARY_SCAN_REGS_VH

// ==========================================================================
// Instruction register
`define IR_WIDTH        5
`define IR_CAPTURE      5'h01
`define IR_RESET_VALUE  5'h09

// ==========================================================================
// Instruction codes
`define INSTR_EXTEST    5'h00
`define INSTR_SAMPLE    5'h01
`define INSTR_USER_A    5'h02
`define INSTR_USER_B    5'h03
`define INSTR_CFG_READ  5'h04
`define INSTR_CFG_WRITE 5'h05
`define INSTR_INTEST    5'h07
`define INSTR_USERCODE  5'h08
`define INSTR_IDCODE    5'h09
`define INSTR_HIGHZ     5'h0A
`define INSTR_STARTUP   5'h0C
`define INSTR_BYPASS    5'h1F

// ==========================================================================
// Identification register layout
`define ID_WIDTH        32
`define ID_MARKER_BIT   0
`define ID_MAKER_LSB    1
`define ID_ROWS_LSB     12
`define ID_FAMILY_LSB   21
`define ID_VERSION_LSB  28

// ==========================================================================
// Boundary cells per io block
`define CELLS_PER_IO    3
`define CELL_IN         0
`define CELL_OUT        1
`define CELL_OE         2

`endif

// *** hdl/boundary_scan_register.v ***
`default_nettype none

// ==========================================================================
// Capture, shift and update stages of a scan register
module boundary_scan_register #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clock,
  input  wire             reset,
  // Control strobes
  input  wire             captureEn,
  input  wire             shiftEn,
  input  wire             updateEn,
  // Data
  input  wire             serialIn,
  input  wire [WIDTH-1:0] captureData,
  output wire             serialOut,
  output reg  [WIDTH-1:0] updateData
);

  reg [WIDTH-1:0] shiftReg;

  // Capture has priority over shift; bit 0 sits next to the serial output
  always @(posedge clock)
  begin
    if (reset)
    begin
      shiftReg   <= {WIDTH{1'b0}};
      updateData <= {WIDTH{1'b0}};
    end
    else
    begin
      if (captureEn)
        shiftReg <= captureData;
      else if (shiftEn)
        shiftReg <= {serialIn, shiftReg[WIDTH-1:1]};
      if (updateEn)
        updateData <= shiftReg;
    end
  end

  assign serialOut = shiftReg[0];

endmodule

`default_nettype wire

// *** hdl/boundary_scan_tap.v ***
`include "boundary_scan_regs.vh"
`default_nettype none

// Summary of operation
// - Codes 00000, 00001, 00111 pick extest, sample/preload, intest on boundary register.
// - Code 00010 routes scan through user chain A, 00011 through chain B.
// - Code 00100 reads configuration bus serially, 00101 writes it.
// - Code 01000 shifts out user code, 01001 shifts out fixed identification.
// - Code 01010 floats all outputs and puts bypass bit in path.
// - Code 01100 steps start-up from test clock only when that source is chosen.
// - Code 11111 selects a one flip-flop bypass retiming serial data.
// - User chain codes act only after configuration; other codes always.
// - Each io block holds input, output and output-enable cells.
// - Input-only pins hold just an input cell.
// - All io blocks form one chain of tristate cells, usable before and after configuration.
// - Capture under extest samples every input, output and enable cell.
// - Two select outputs decode the two user chain codes.
// - Active chain's scan return is forwarded to test data out.
// - Each chain gets its own shift clock; one shared serial input.
// - Outputs show controller reset, shift and update states.
// - Cell order within an io block is input, output, enable.
// - Identification is version, family, rows, maker, then a constant one.
// - User code comes from configuration and is valid after it finishes.
module boundary_scan_tap #(
  parameter NUM_IO      = 4,
  parameter NUM_IN      = 2,
  // Identification fields: values are arbitrary
  parameter [3:0]  ID_VERSION = 4'h0,
  parameter [6:0]  ID_FAMILY  = 7'h15,
  parameter [8:0]  ID_ROWS    = 9'h020,
  parameter [10:0] ID_MAKER   = 11'h2AA
) (
  // Clock and reset
  input  wire              clock,
  input  wire              reset,
  // Test port pins
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo,
  output reg               tdoOe,
  // Pads
  input  wire [NUM_IO-1:0] ioPadIn,
  output reg  [NUM_IO-1:0] ioPadOut,
  output reg  [NUM_IO-1:0] ioPadOe,
  input  wire [NUM_IN-1:0] inPadIn,
  // Core side of the pads
  input  wire [NUM_IO-1:0] coreOut,
  input  wire [NUM_IO-1:0] coreOe,
  output reg  [NUM_IO-1:0] coreIn,
  output reg  [NUM_IN-1:0] coreInOnly,
  // Configuration bus
  input  wire              configDone,
  input  wire [31:0]       userCode,
  input  wire              cfgReadBit,
  output reg               cfgReadStrobe,
  output reg               cfgWriteBit,
  output reg               cfgWriteStrobe,
  input  wire              startupClockSource,
  output reg               startupStep,
  // User scan chains
  output reg               chainASelected,
  output reg               chainBSelected,
  input  wire              chainAScanReturn,
  input  wire              chainBScanReturn,
  output reg               chainAShiftClock,
  output reg               chainBShiftClock,
  output reg               userTdi,
  output reg               tapReset,
  output reg               tapShift,
  output reg               tapUpdate
);

  // ========================================================================
  // Controller states
  localparam [3:0] ST_RESET      = 4'h0;
  localparam [3:0] ST_IDLE       = 4'h1;
  localparam [3:0] ST_SEL_DR     = 4'h2;
  localparam [3:0] ST_CAP_DR     = 4'h3;
  localparam [3:0] ST_SHIFT_DR   = 4'h4;
  localparam [3:0] ST_EXIT1_DR   = 4'h5;
  localparam [3:0] ST_PAUSE_DR   = 4'h6;
  localparam [3:0] ST_EXIT2_DR   = 4'h7;
  localparam [3:0] ST_UPDATE_DR  = 4'h8;
  localparam [3:0] ST_SEL_IR     = 4'h9;
  localparam [3:0] ST_CAP_IR     = 4'hA;
  localparam [3:0] ST_SHIFT_IR   = 4'hB;
  localparam [3:0] ST_EXIT1_IR   = 4'hC;
  localparam [3:0] ST_PAUSE_IR   = 4'hD;
  localparam [3:0] ST_EXIT2_IR   = 4'hE;
  localparam [3:0] ST_UPDATE_IR  = 4'hF;

  localparam BS_LEN = `CELLS_PER_IO * NUM_IO + NUM_IN;

  // ========================================================================
  // Declarations
  reg  [2:0]              pinMeta;
  reg  [2:0]              pinSync;
  reg                     tckPrev;
  reg  [NUM_IO-1:0]       ioMeta;
  reg  [NUM_IO-1:0]       ioSync;
  reg  [NUM_IN-1:0]       inMeta;
  reg  [NUM_IN-1:0]       inSync;
  reg  [3:0]              state;
  reg  [3:0]              next_state;
  reg  [`IR_WIDTH-1:0]    irShift;
  reg  [`IR_WIDTH-1:0]    instr;
  reg  [`ID_WIDTH-1:0]    idShift;
  reg                     bypassBit;
  reg                     drOut;
  reg  [BS_LEN-1:0]       bsCapture;
  wire [BS_LEN-1:0]       bsUpdate;
  wire                    bsSerialOut;
  wire                    tckLevel;
  wire                    tmsLevel;
  wire                    tdiLevel;
  wire                    tckRise;
  wire                    tckFall;
  wire                    bsInstr;
  wire                    boundaryDrive;
  wire                    selA;
  wire                    selB;
  wire                    drCapture;
  wire                    drShift;
  wire [`ID_WIDTH-1:0]    idValue;
  integer                 k;
  integer                 j;

  // ========================================================================
  // Pin synchronisers and test clock edges
  always @(posedge clock)
  begin
    if (reset)
    begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      tckPrev <= 1'b0;
      ioMeta  <= {NUM_IO{1'b0}};
      ioSync  <= {NUM_IO{1'b0}};
      inMeta  <= {NUM_IN{1'b0}};
      inSync  <= {NUM_IN{1'b0}};
    end
    else
    begin
      pinMeta <= {tdi, tms, tck};
      pinSync <= pinMeta;
      tckPrev <= pinSync[0];
      ioMeta  <= ioPadIn;
      ioSync  <= ioMeta;
      inMeta  <= inPadIn;
      inSync  <= inMeta;
    end
  end

  assign tckLevel = pinSync[0];
  assign tmsLevel = pinSync[1];
  assign tdiLevel = pinSync[2];
  assign tckRise  = tckLevel & ~tckPrev;
  assign tckFall  = ~tckLevel & tckPrev;

  // ========================================================================
  // Controller next state
  always @*
  begin
    next_state = ST_RESET;
    case (state)
      ST_RESET:     next_state = tmsLevel ? ST_RESET     : ST_IDLE;
      ST_IDLE:      next_state = tmsLevel ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_DR:    next_state = tmsLevel ? ST_SEL_IR    : ST_CAP_DR;
      ST_CAP_DR:    next_state = tmsLevel ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:  next_state = tmsLevel ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:  next_state = tmsLevel ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:  next_state = tmsLevel ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:  next_state = tmsLevel ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: next_state = tmsLevel ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_IR:    next_state = tmsLevel ? ST_RESET     : ST_CAP_IR;
      ST_CAP_IR:    next_state = tmsLevel ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:  next_state = tmsLevel ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:  next_state = tmsLevel ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:  next_state = tmsLevel ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:  next_state = tmsLevel ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: next_state = tmsLevel ? ST_SEL_DR    : ST_IDLE;
      default:      next_state = ST_RESET;
    endcase
  end

  // Controller state moves on the rising test clock edge
  always @(posedge clock)
  begin
    if (reset)
      state <= ST_RESET;
    else if (tckRise)
      state <= next_state;
  end

  // ========================================================================
  // Instruction register: shift on rise, load on falling edge in update
  always @(posedge clock)
  begin
    if (reset)
    begin
      irShift <= `IR_CAPTURE;
      instr   <= `IR_RESET_VALUE;
    end
    else if (state == ST_RESET)
    begin
      irShift <= `IR_CAPTURE;
      instr   <= `IR_RESET_VALUE;
    end
    else
    begin
      if (tckRise && state == ST_CAP_IR)
        irShift <= `IR_CAPTURE;
      else if (tckRise && state == ST_SHIFT_IR)
        irShift <= {tdiLevel, irShift[`IR_WIDTH-1:1]};
      if (tckFall && state == ST_UPDATE_IR)
        instr <= irShift;
    end
  end

  // ========================================================================
  // Instruction decode
  assign bsInstr = (instr == `INSTR_EXTEST) | (instr == `INSTR_SAMPLE) |
                   (instr == `INSTR_INTEST);
  assign boundaryDrive = (instr == `INSTR_EXTEST) | (instr == `INSTR_INTEST);
  assign selA = (instr == `INSTR_USER_A) & configDone;
  assign selB = (instr == `INSTR_USER_B) & configDone;
  assign drCapture = tckRise & (state == ST_CAP_DR);
  assign drShift   = tckRise & (state == ST_SHIFT_DR);

  // ========================================================================
  // Boundary register capture vector: in, out, enable per io block
  always @*
  begin
    bsCapture = {BS_LEN{1'b0}};
    for (k = 0; k < NUM_IO; k = k + 1)
    begin
      bsCapture[`CELLS_PER_IO*k + `CELL_IN]  = ioSync[k];
      bsCapture[`CELLS_PER_IO*k + `CELL_OUT] = coreOut[k];
      bsCapture[`CELLS_PER_IO*k + `CELL_OE]  = coreOe[k];
    end
    for (k = 0; k < NUM_IN; k = k + 1)
      bsCapture[`CELLS_PER_IO*NUM_IO + k] = inSync[k];
  end

  // One chain for all io blocks, independent of pad configuration
  boundary_scan_register #(
    .WIDTH       (BS_LEN)
  ) u_boundary (
    .clock       (clock),
    .reset       (reset),
    .captureEn   (drCapture & bsInstr),
    .shiftEn     (drShift & bsInstr),
    .updateEn    (tckFall & (state == ST_UPDATE_DR) & bsInstr),
    .serialIn    (tdiLevel),
    .captureData (bsCapture),
    .serialOut   (bsSerialOut),
    .updateData  (bsUpdate)
  );

  // ========================================================================
  // Identification, user code and bypass registers
  assign idValue = {ID_VERSION, ID_FAMILY, ID_ROWS, ID_MAKER, 1'b1};

  always @(posedge clock)
  begin
    if (reset)
    begin
      idShift   <= {`ID_WIDTH{1'b0}};
      bypassBit <= 1'b0;
    end
    else
    begin
      if (drCapture && instr == `INSTR_IDCODE)
        idShift <= idValue;
      else if (drCapture && instr == `INSTR_USERCODE)
        idShift <= configDone ? userCode : {`ID_WIDTH{1'b1}};
      else if (drShift)
        idShift <= {tdiLevel, idShift[`ID_WIDTH-1:1]};
      if (drCapture)
        bypassBit <= 1'b0;
      else if (drShift)
        bypassBit <= tdiLevel;
    end
  end

  // ========================================================================
  // Serial output source for the selected data register
  always @*
  begin
    case (instr)
      `INSTR_EXTEST,
      `INSTR_SAMPLE,
      `INSTR_INTEST:   drOut = bsSerialOut;
      `INSTR_USER_A:   drOut = selA ? chainAScanReturn : bypassBit;
      `INSTR_USER_B:   drOut = selB ? chainBScanReturn : bypassBit;
      `INSTR_CFG_READ: drOut = cfgReadBit;
      `INSTR_USERCODE,
      `INSTR_IDCODE:   drOut = idShift[0];
      `INSTR_HIGHZ:    drOut = bypassBit;
      `INSTR_BYPASS:   drOut = bypassBit;
      default:         drOut = bypassBit;
    endcase
  end

  // Test data out changes on the falling test clock edge
  always @(posedge clock)
  begin
    if (reset)
    begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end
    else if (tckFall)
    begin
      if (state == ST_SHIFT_IR)
      begin
        tdo   <= irShift[0];
        tdoOe <= 1'b1;
      end
      else if (state == ST_SHIFT_DR)
      begin
        tdo   <= drOut;
        tdoOe <= 1'b1;
      end
      else
        tdoOe <= 1'b0;
    end
  end

  // ========================================================================
  // Pad and core steering
  always @(posedge clock)
  begin
    if (reset)
    begin
      ioPadOut   <= {NUM_IO{1'b0}};
      ioPadOe    <= {NUM_IO{1'b0}};
      coreIn     <= {NUM_IO{1'b0}};
      coreInOnly <= {NUM_IN{1'b0}};
    end
    else
    begin
      for (j = 0; j < NUM_IO; j = j + 1)
      begin
        ioPadOut[j] <= boundaryDrive ? bsUpdate[`CELLS_PER_IO*j + `CELL_OUT] : coreOut[j];
        if (instr == `INSTR_HIGHZ)
          ioPadOe[j] <= 1'b0;
        else if (boundaryDrive)
          ioPadOe[j] <= bsUpdate[`CELLS_PER_IO*j + `CELL_OE];
        else
          ioPadOe[j] <= coreOe[j];
        coreIn[j] <= (instr == `INSTR_INTEST) ?
                     bsUpdate[`CELLS_PER_IO*j + `CELL_IN] : ioSync[j];
      end
      for (j = 0; j < NUM_IN; j = j + 1)
        coreInOnly[j] <= (instr == `INSTR_INTEST) ?
                         bsUpdate[`CELLS_PER_IO*NUM_IO + j] : inSync[j];
    end
  end

  // ========================================================================
  // Configuration bus and start-up stepping
  always @(posedge clock)
  begin
    if (reset)
    begin
      cfgReadStrobe  <= 1'b0;
      cfgWriteBit    <= 1'b0;
      cfgWriteStrobe <= 1'b0;
      startupStep    <= 1'b0;
    end
    else
    begin
      cfgReadStrobe  <= drShift & (instr == `INSTR_CFG_READ);
      cfgWriteStrobe <= drShift & (instr == `INSTR_CFG_WRITE);
      if (drShift && instr == `INSTR_CFG_WRITE)
        cfgWriteBit <= tdiLevel;
      startupStep <= tckRise & (state == ST_IDLE) &
                     (instr == `INSTR_STARTUP) & startupClockSource;
    end
  end

  // ========================================================================
  // User scan macro outputs
  always @(posedge clock)
  begin
    if (reset)
    begin
      chainASelected   <= 1'b0;
      chainBSelected   <= 1'b0;
      chainAShiftClock <= 1'b1;
      chainBShiftClock <= 1'b1;
      userTdi          <= 1'b0;
      tapReset         <= 1'b1;
      tapShift         <= 1'b0;
      tapUpdate        <= 1'b0;
    end
    else
    begin
      chainASelected <= selA;
      chainBSelected <= selB;
      // Shift clocks follow the test clock only while capturing or shifting
      chainAShiftClock <= (selA && (state == ST_CAP_DR || state == ST_SHIFT_DR)) ?
                          tckLevel : 1'b1;
      chainBShiftClock <= (selB && (state == ST_CAP_DR || state == ST_SHIFT_DR)) ?
                          tckLevel : 1'b1;
      userTdi   <= tdiLevel;
      tapReset  <= (state == ST_RESET);
      tapShift  <= (state == ST_SHIFT_DR);
      tapUpdate <= (state == ST_UPDATE_DR);
    end
  end

endmodule

`default_nettype wire

// *** bench/tap_monitor.sv ***
`default_nettype none
// ==========================================================================
// Port checker for the test access port
module tap_monitor #(
  parameter NUM_IO = 4
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // Watched ports
  input wire logic              tdoOe,
  input wire logic [NUM_IO-1:0] ioPadOe,
  input wire logic              configDone,
  input wire logic              cfgReadStrobe,
  input wire logic              cfgWriteStrobe,
  input wire logic              startupClockSource,
  input wire logic              startupStep,
  input wire logic              chainASelected,
  input wire logic              chainBSelected,
  input wire logic              chainAShiftClock,
  input wire logic              chainBShiftClock,
  input wire logic              tapReset,
  input wire logic              tapShift,
  input wire logic              tapUpdate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========================================================================
  // Assertions
  sel_excl_a: assert property (!(chainASelected && chainBSelected))
    else $error("both chain selects high");
  sel_config_a: assert property ((chainASelected || chainBSelected) |-> $past(configDone))
    else $error("chain selected before configuration");
  state_excl_a: assert property ($onehot0({tapReset, tapShift, tapUpdate}))
    else $error("controller state outputs overlap");
  reset_state_a: assert property ($past(reset) |-> tapReset && !tdoOe && ioPadOe == '0)
    else $error("wrong state after reset");
  shift_oe_a: assert property (tapShift [*6] |-> tdoOe)
    else $error("serial output not enabled in shift");
  chain_clock_a: assert property ((chainAShiftClock || chainASelected) &&
    (chainBShiftClock || chainBSelected))
    else $error("shift clock moves on unselected chain");
  cfg_shift_a: assert property ((cfgReadStrobe || cfgWriteStrobe) |-> $past(tapShift))
    else $error("configuration strobe outside shift");
  cfg_pulse_a: assert property ((cfgReadStrobe || cfgWriteStrobe) |=>
    !(cfgReadStrobe || cfgWriteStrobe))
    else $error("configuration strobe longer than one clock");
  step_gate_a: assert property (startupStep |-> $past(startupClockSource) ##1 !startupStep)
    else $error("start-up step without test clock source");
endmodule
`default_nettype wire

// *** bench/jtag_host_model.sv ***
`default_nettype none
// ==========================================================================
// External test controller driving the test port pins
module jtag_host_model (
  // System clock used to pace the pins
  input  wire logic clock,
  // Test port pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Test clock stands low until the first frame
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock period, eight system clocks; output read before next fall
  task automatic step(input logic m, input logic v, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = v;
    repeat (4) @(negedge clock);
    tck = 1'b1;
    repeat (4) @(negedge clock);
    o = tdo;
  endtask
  // From run-test/idle through one shift path and back, LSB first
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir)
      step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // Five high mode bits reach reset, then idle for n periods
  task automatic idle(input logic toReset, input int n);
    logic o;
    if (toReset)
      repeat (5) step(1'b1, ~tdi, o);
    repeat (n) step(1'b0, ~tdi, o);
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); \
    end \
  end
// ==========================================================================
// Top of the bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Identification fields, values arbitrary
  localparam logic [31:0] EXP_ID = {4'h5, 7'h2A, 9'h0C3, 11'h155, 1'b1};
  localparam logic [13:0] PRE    = 14'h1A5B;
  logic        clock, reset, tck, tms, tdi, tdo, tdoOe;
  logic [3:0]  ioPadIn, ioPadOut, ioPadOe, coreOut, coreOe, coreIn;
  logic [1:0]  inPadIn, coreInOnly;
  logic        configDone, cfgReadBit, cfgReadStrobe, cfgWriteBit, cfgWriteStrobe;
  logic [31:0] userCode;
  logic        startupClockSource, startupStep, chainASelected, chainBSelected;
  logic        chainAScanReturn, chainBScanReturn, chainAShiftClock, chainBShiftClock;
  logic        userTdi, tapReset, tapShift, tapUpdate;
  logic [63:0] d;
  logic [7:0]  wrBits;
  int          fails, checked, rdCnt, stepCnt, aLow, upCnt;
  // Released serial line floats high
  wire logic   tdoLine = tdoOe ? tdo : 1'b1;
  // ==========================================================================
  // Design and far-side controller
  boundary_scan_tap #(.NUM_IO(4), .NUM_IN(2), .ID_VERSION(4'h5), .ID_FAMILY(7'h2A),
    .ID_ROWS(9'h0C3), .ID_MAKER(11'h155)) dut (.clock(clock), .reset(reset), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .ioPadIn(ioPadIn), .ioPadOut(ioPadOut),
    .ioPadOe(ioPadOe), .inPadIn(inPadIn), .coreOut(coreOut), .coreOe(coreOe),
    .coreIn(coreIn), .coreInOnly(coreInOnly), .configDone(configDone), .userCode(userCode),
    .cfgReadBit(cfgReadBit), .cfgReadStrobe(cfgReadStrobe), .cfgWriteBit(cfgWriteBit),
    .cfgWriteStrobe(cfgWriteStrobe), .startupClockSource(startupClockSource),
    .startupStep(startupStep), .chainASelected(chainASelected),
    .chainBSelected(chainBSelected), .chainAScanReturn(chainAScanReturn),
    .chainBScanReturn(chainBScanReturn), .chainAShiftClock(chainAShiftClock),
    .chainBShiftClock(chainBShiftClock), .userTdi(userTdi), .tapReset(tapReset),
    .tapShift(tapShift), .tapUpdate(tapUpdate));
  jtag_host_model ctl (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));
  // Clock and side counters for strobes, steps and shift clock activity
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    rdCnt += cfgReadStrobe;
    stepCnt += startupStep;
    aLow += !chainAShiftClock;
    upCnt += tapUpdate;
    if (cfgWriteStrobe)
      wrBits = {cfgWriteBit, wrBits[7:1]};
  end
  // ==========================================================================
  // Shift helpers and closing report
  task automatic ir(input logic [4:0] c);
    ctl.scan(1'b1, 5, {59'h0, c}, d);
  endtask
  task automatic dr(input int n, input logic [63:0] v);
    ctl.scan(1'b0, n, v, d);
  endtask
  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic testIdcode;
    `CHK(tapReset, 1'b1)
    ctl.idle(1'b1, 1);
    dr(32, 64'h0);
    `CHK(d[31:0], EXP_ID)
    ir(5'h09);
    `CHK(d[4:0], 5'h01)
    dr(32, 64'h0);
    `CHK(d[31:0], EXP_ID)
    $display("testIdcode done");
  endtask
  task automatic testBoundary;
    logic [13:0] exp;
    logic [3:0]  po;
    logic [3:0]  pe;
    configDone = 1'b1; // Configured before any boundary work
    for (int k = 0; k < 4; k++)
    begin
      exp[3*k] = ioPadIn[k];
      exp[3*k+1] = coreOut[k];
      exp[3*k+2] = coreOe[k];
      po[k] = PRE[3*k+1];
      pe[k] = PRE[3*k+2];
    end
    exp[13:12] = inPadIn;
    ir(5'h01);
    dr(14, {50'h0, PRE});
    `CHK(d[13:0], exp)
    ir(5'h00);
    `CHK(ioPadOut, po)
    `CHK(ioPadOe, pe)
    ioPadIn = 4'h5;
    inPadIn = 2'h2;
    dr(14, {50'h0, PRE});
    for (int k = 0; k < 4; k++)
      `CHK(d[3*k], ioPadIn[k])
    `CHK(d[13:12], inPadIn)
    ir(5'h07);
    for (int k = 0; k < 4; k++)
      `CHK(coreIn[k], PRE[3*k])
    `CHK(coreInOnly, PRE[13:12])
    $display("testBoundary done");
  endtask
  task automatic testBypass;
    logic [4:0] codes [8] = '{5'h1F, 5'h0A, 5'h0C, 5'h05, 5'h06, 5'h0B, 5'h1E, 5'h10};
    foreach (codes[i])
    begin
      ir(codes[i]);
      if (codes[i] == 5'h0A)
        `CHK(ioPadOe, 4'h0)
      dr(8, 64'hB5);
      `CHK(d[7:0], 8'h6A)
    end
    $display("testBypass done");
  endtask
  task automatic testUser;
    configDone = 1'b0;
    ir(5'h02);
    `CHK(chainASelected, 1'b0)
    dr(4, 64'h0);
    `CHK(d[3:0], 4'h0)
    configDone = 1'b1;
    ir(5'h02);
    `CHK(chainASelected, 1'b1)
    `CHK(chainBSelected, 1'b0)
    aLow = 0;
    dr(4, 64'h0);
    `CHK(d[3:0], 4'hF)
    `CHK(aLow > 0, 1'b1)
    ir(5'h03);
    `CHK(chainBSelected, 1'b1)
    dr(4, 64'hF);
    `CHK(d[3:0], 4'h0)
    $display("testUser done");
  endtask
  task automatic testCodes;
    ir(5'h08);
    dr(32, 64'h0);
    `CHK(d[31:0], userCode)
    configDone = 1'b0;
    dr(32, 64'h0);
    `CHK(d[31:0], 32'hFFFFFFFF)
    configDone = 1'b1;
    ir(5'h04);
    rdCnt = 0;
    upCnt = 0;
    dr(6, 64'h0);
    `CHK(d[5:0], 6'h3F)
    `CHK(rdCnt, 6)
    `CHK(upCnt, 8)
    cfgReadBit = 1'b0;
    dr(4, 64'hF);
    `CHK(d[3:0], 4'h0)
    ir(5'h05);
    dr(8, 64'hC5);
    `CHK(wrBits, 8'hC5)
    $display("testCodes done");
  endtask
  task automatic testStartup;
    startupClockSource = 1'b1;
    ir(5'h0C);
    stepCnt = 0;
    ctl.idle(1'b0, 3);
    repeat (4) @(negedge clock);
    `CHK(stepCnt, 3)
    startupClockSource = 1'b0;
    stepCnt = 0;
    ctl.idle(1'b0, 3);
    repeat (4) @(negedge clock);
    `CHK(stepCnt, 0)
    $display("testStartup done");
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    repeat (100000) @(posedge clock);
    fails++;
    end_sim;
  end
  // Main sequence
  initial
  begin
    {fails, checked, rdCnt, stepCnt, aLow, upCnt} = '0;
    wrBits = 8'h00;
    reset = 1'b1;
    {ioPadIn, coreOut, coreOe, inPadIn} = {4'hA, 4'h6, 4'hC, 2'h1};
    {configDone, cfgReadBit, startupClockSource} = 3'h2;
    {chainAScanReturn, chainBScanReturn} = 2'h2;
    userCode = 32'h5A3C96E1;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    testIdcode;
    testBoundary;
    testBypass;
    testUser;
    testCodes;
    testStartup;
    end_sim;
  end
endmodule
bind boundary_scan_tap tap_monitor #(.NUM_IO(NUM_IO)) mon (.clock(clock), .reset(reset),
  .tdoOe(tdoOe), .ioPadOe(ioPadOe), .configDone(configDone), .cfgReadStrobe(cfgReadStrobe),
  .cfgWriteStrobe(cfgWriteStrobe), .startupClockSource(startupClockSource),
  .startupStep(startupStep), .chainASelected(chainASelected),
  .chainBSelected(chainBSelected), .chainAShiftClock(chainAShiftClock),
  .chainBShiftClock(chainBShiftClock), .tapReset(tapReset), .tapShift(tapShift),
  .tapUpdate(tapUpdate));
`default_nettype wire
